// ### rtl/pdps_top.sv
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "pdps_regs.svh"

module pdps_top
  import pdps_pkg::*;
#(
  parameter int ADDR_W = 12  // byte address width seen by the slave
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // operating mode straps
  input  wire logic              mode_ext_rom_off,
  input  wire logic              mode_bus16,
  // function sides, bit k serves pin 8+k
  input  wire pdps_drive_t       gpio_drv,
  output logic [7:0]             gpio_in,
  input  wire pdps_drive_t       ebc_drv,
  output logic [7:0]             ebc_in,
  input  wire pdps_drive_t       trace_drv,
  output logic [7:0]             trace_in,
  // the pins themselves
  input  wire logic [7:0]        pin_in,
  output pdps_drive_t            pin_drv
);

  // the decoder compares at least the status offset
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
    $error("pdps_top: ADDR_W must be 5 to 32");
  end

  pdps_state_t st_reg;   // all state
  pdps_state_t st_next;  // its next value

  logic [7:0]  sel_upper;   // upper select bit per pin
  logic [7:0]  sel_lower;   // lower select bit per pin
  logic [7:0]  mux_o;       // mux drive level
  logic [7:0]  mux_oe;      // mux drive enable
  logic [7:0]  mux_gpio_i;  // pin level to port
  logic [7:0]  mux_ebc_i;   // pin level to bus controller
  logic [7:0]  mux_trc_i;   // pin level to trace port
  logic [7:0]  mux_bad;     // forbidden code per pin
  logic        take;        // address phase accepted
  pdps_reg_t   addr_idx;    // decoded register

  // select bits straight from the stored registers
  assign sel_upper = st_reg.low_b_hi;
  assign sel_lower = st_reg.low_a[15:8];

  // one mux per pin; trace mode and reset are input-only
  for (genvar k = 0; k < `PDPS_PIN_CNT; k++) begin : g_pin
    pdps_pin_mux #(
      .TRACE_DRIVES(((`PDPS_TRC_IN_ONLY >> k) & 8'h01) == 8'h00)
    ) u_mux (
      .sel    ({sel_upper[k], sel_lower[k]}),
      .gpio_o (gpio_drv.out[k]),
      .gpio_oe(gpio_drv.oe[k]),
      .ebc_o  (ebc_drv.out[k]),
      .ebc_oe (ebc_drv.oe[k]),
      .trc_o  (trace_drv.out[k]),
      .trc_oe (trace_drv.oe[k]),
      .pin_i  (pin_in[k]),
      .pin_o  (mux_o[k]),
      .pin_oe (mux_oe[k]),
      .gpio_i (mux_gpio_i[k]),
      .ebc_i  (mux_ebc_i[k]),
      .trc_i  (mux_trc_i[k]),
      .bad    (mux_bad[k])
    );
  end

  // word address decode; anything else is unmapped
  function automatic pdps_reg_t decode(input logic [ADDR_W-1:0] a);
    pdps_reg_t r;
    r = PDPS_R_NONE;
    if (a == ADDR_W'(`PDPS_OFF_LOW_A)) begin
      r = PDPS_R_LOW_A;
    end else if (a == ADDR_W'(`PDPS_OFF_LOW_B)) begin
      r = PDPS_R_LOW_B;
    end else if (a == ADDR_W'(`PDPS_OFF_HIGH_A)) begin
      r = PDPS_R_HIGH_A;
    end else if (a == ADDR_W'(`PDPS_OFF_HIGH_B)) begin
      r = PDPS_R_HIGH_B;
    end else if (a == ADDR_W'(`PDPS_OFF_STATUS)) begin
      r = PDPS_R_STATUS;
    end
    return r;
  endfunction

  // address phase taken on any nonseq or seq with the bus ready
  assign take = hsel && hready && htrans[1];
  assign addr_idx = decode(haddr);

  // next-state logic: init, write commit, read capture, pin outputs
  always_comb begin
    st_next = st_reg;
    st_next.hready = 1'b1;  // zero wait states, never stalls
    case (st_reg.phase)
      PDPS_PH_STRAP: begin
        // straps caught one edge after reset release
        st_next.low_a[15:8] = {8{mode_ext_rom_off & mode_bus16}};
        st_next.low_a[7:0]  = {8{mode_ext_rom_off}};
        st_next.low_b_hi    = `PDPS_RST_UPPER;
        st_next.wr_pend     = 1'b0;
        st_next.rdata       = 32'h0000_0000;
        st_next.phase       = PDPS_PH_RUN;
      end
      PDPS_PH_RUN: begin
        // data phase of a pending write commits hwdata
        if (st_reg.wr_pend && hready) begin
          case (st_reg.wr_idx)
            PDPS_R_LOW_A: begin
              st_next.low_a = hwdata[15:0];
            end
            PDPS_R_LOW_B: begin
              // low byte is reserved, not stored
              st_next.low_b_hi = hwdata[15:8];
            end
            default: begin
              // high registers and status keep nothing
            end
          endcase
        end
        // only whole-word writes are committed
        st_next.wr_pend = take && hwrite && (hsize == `PDPS_HSIZE_WORD);
        st_next.wr_idx  = addr_idx;
        // read data for the next data phase, after any commit above
        st_next.rdata = 32'h0000_0000;
        if (take && !hwrite) begin
          case (addr_idx)
            PDPS_R_LOW_A: begin
              st_next.rdata = {16'h0000, st_next.low_a};
            end
            PDPS_R_LOW_B: begin
              st_next.rdata = {16'h0000, st_next.low_b_hi, 8'h00};
            end
            PDPS_R_STATUS: begin
              // which pins hold trace or forbidden codes
              st_next.rdata = {16'h0000, sel_upper & ~sel_lower, mux_bad};
            end
            default: begin
              // high registers reserved, unmapped reads zero
              st_next.rdata = 32'h0000_0000;
            end
          endcase
        end
      end
      default: begin
        st_next.phase = PDPS_PH_STRAP;
      end
    endcase
    // pins follow the stored select one edge later
    st_next.pin.out  = mux_o;
    st_next.pin.oe   = mux_oe;
    st_next.gpio_in  = mux_gpio_i;
    st_next.ebc_in   = mux_ebc_i;
    st_next.trace_in = mux_trc_i;
  end

  // one register for everything; reset takes only constants
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.low_a[15:8] <= `PDPS_RST_LOWER;
      st_reg.low_b_hi <= `PDPS_RST_UPPER;
      st_reg.hready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // every output but hresp taken from the state register; hresp is tied to okay
  assign hreadyout = st_reg.hready;
  assign hrdata    = st_reg.rdata;
  assign hresp     = `PDPS_HRESP_OKAY;
  assign pin_drv   = st_reg.pin;
  assign gpio_in   = st_reg.gpio_in;
  assign ebc_in    = st_reg.ebc_in;
  assign trace_in  = st_reg.trace_in;

endmodule

// ### shared/pdps_regs.svh
`ifndef PDPS_REGS_SVH
`define PDPS_REGS_SVH

// register byte offsets on the bus
`define PDPS_OFF_LOW_A    32'h0000_0000
`define PDPS_OFF_LOW_B    32'h0000_0004
`define PDPS_OFF_HIGH_A   32'h0000_0008
`define PDPS_OFF_HIGH_B   32'h0000_000c
`define PDPS_OFF_STATUS   32'h0000_0010

// field layout: pins 8..15 sit in bits 15..8 of the low registers
`define PDPS_PIN_LO       8
`define PDPS_PIN_CNT      8
`define PDPS_REG_W        16

// reset values of the stored fields
`define PDPS_RST_UPPER    8'h00
`define PDPS_RST_LOWER    8'h00

// trace functions that the pin may not drive (mode and reset inputs)
`define PDPS_TRC_IN_ONLY  8'h30

// bus encodings
`define PDPS_HSIZE_WORD   3'h2
`define PDPS_HRESP_OKAY   1'h0

`endif

// ### shared/pdps_pkg.sv
package pdps_pkg;

  // select field encodings
  typedef enum logic [1:0] {
    PDPS_SEL_GPIO  = 2'b00,
    PDPS_SEL_EBC   = 2'b01,
    PDPS_SEL_TRACE = 2'b10,
    PDPS_SEL_BAD   = 2'b11
  } pdps_sel_t;

  // init sequence: catch straps once, then run
  typedef enum logic [0:0] {
    PDPS_PH_STRAP = 1'b0,
    PDPS_PH_RUN   = 1'b1
  } pdps_phase_t;

  // decoded register index
  typedef enum logic [2:0] {
    PDPS_R_LOW_A  = 3'b000,
    PDPS_R_LOW_B  = 3'b001,
    PDPS_R_HIGH_A = 3'b010,
    PDPS_R_HIGH_B = 3'b011,
    PDPS_R_STATUS = 3'b100,
    PDPS_R_NONE   = 3'b111
  } pdps_reg_t;

  // drive of one eight-pin group
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pdps_drive_t;

  // whole state of the top module
  typedef struct packed {
    pdps_phase_t phase;
    logic [15:0] low_a;
    logic [7:0]  low_b_hi;
    logic        wr_pend;
    pdps_reg_t   wr_idx;
    logic [31:0] rdata;
    logic        hready;
    pdps_drive_t pin;
    logic [7:0]  gpio_in;
    logic [7:0]  ebc_in;
    logic [7:0]  trace_in;
  } pdps_state_t;

endpackage

// ### rtl/pdps_pin_mux.sv
`timescale 1ns/1ps
// one pin of the upper byte: routes drive out and the pin level in
module pdps_pin_mux
  import pdps_pkg::*;
#(
  parameter bit TRACE_DRIVES = 1'b1  // 0 for input-only trace functions
) (
  input  wire logic [1:0] sel,
  input  wire logic       gpio_o,
  input  wire logic       gpio_oe,
  input  wire logic       ebc_o,
  input  wire logic       ebc_oe,
  input  wire logic       trc_o,
  input  wire logic       trc_oe,
  input  wire logic       pin_i,
  output logic            pin_o,
  output logic            pin_oe,
  output logic            gpio_i,
  output logic            ebc_i,
  output logic            trc_i,
  output logic            bad
);

  // only the selected function drives or sees the pin
  always_comb begin
    pin_o  = 1'b0;
    pin_oe = 1'b0;
    gpio_i = 1'b0;
    ebc_i  = 1'b0;
    trc_i  = 1'b0;
    bad    = 1'b0;
    case (pdps_sel_t'(sel))
      PDPS_SEL_GPIO: begin  // general port
        pin_o  = gpio_o;
        pin_oe = gpio_oe;
        gpio_i = pin_i;
      end
      PDPS_SEL_EBC: begin  // data-bus bit
        pin_o  = ebc_o;
        pin_oe = ebc_oe;
        ebc_i  = pin_i;
      end
      PDPS_SEL_TRACE: begin  // trace port signal
        pin_o  = TRACE_DRIVES ? trc_o : 1'b0;
        pin_oe = TRACE_DRIVES ? trc_oe : 1'b0;
        trc_i  = pin_i;
      end
      default: begin
        // forbidden code: pin left undriven, nobody sees it
        bad = 1'b1;
      end
    endcase
  end

endmodule

// ### tb/pdps_top_asserts.sv
`timescale 1ns/1ps
// port-level checks of the upper-byte pin selector
module pdps_top_asserts
  import pdps_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic [31:0]       hrdata,
  input wire logic              hresp,
  input wire pdps_drive_t       gpio_drv,
  input wire pdps_drive_t       ebc_drv,
  input wire pdps_drive_t       trace_drv,
  input wire logic [7:0]        gpio_in,
  input wire logic [7:0]        ebc_in,
  input wire logic [7:0]        trace_in,
  input wire logic [7:0]        pin_in,
  input wire pdps_drive_t       pin_drv
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic        rd_take; // read taken at this edge
  logic [31:0] a32;     // widened address for compares
  assign rd_take = hsel & hready & htrans[1] & !hwrite;
  assign a32 = 32'(haddr);
  AST_READY: assert property (hreadyout == 1'b1 && hresp == 1'b0)
    else $error("slave not ready or not okay");
  AST_RD_IDLE: assert property (!rd_take |=> hrdata == 32'h0)
    else $error("read data outside data phase");
  AST_RD_UPPER: assert property (rd_take |=> hrdata[31:16] == 16'h0)
    else $error("upper half of read data not zero");
  AST_LOWB_RSVD: assert property (rd_take && a32 == 32'h4
    |=> hrdata[7:0] == 8'h00) else $error("reserved low byte read nonzero");
  AST_HIGH_ZERO: assert property (rd_take && (a32 == 32'h8 ||
    a32 == 32'hc) |=> hrdata == 32'h0) else $error("high register nonzero");
  AST_IN_LEVEL: assert property
    (((gpio_in | ebc_in | trace_in) & ~$past(pin_in)) == 8'h00)
    else $error("function input not from pin level");
  AST_IN_EXCL: assert property (((gpio_in & ebc_in) |
    (gpio_in & trace_in) | (ebc_in & trace_in)) == 8'h00)
    else $error("pin level routed to two functions");
  AST_OE_SRC: assert property ((pin_drv.oe & ~$past(gpio_drv.oe |
    ebc_drv.oe | trace_drv.oe)) == 8'h00) else $error("pin driven unasked");
  AST_TRC_IN_ONLY: assert property ((pin_drv.oe[5:4] &
    ~$past(gpio_drv.oe[5:4] | ebc_drv.oe[5:4])) == 2'b00)
    else $error("trace input pin driven");
endmodule
bind pdps_top pdps_top_asserts #(.ADDR_W(ADDR_W)) chk_u (.ref_clk, .rst_n,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp,
  .gpio_drv, .ebc_drv, .trace_drv, .gpio_in, .ebc_in, .trace_in, .pin_in,
  .pin_drv);

// ### tb/pdps_top_tb_top.sv
`timescale 1ns/1ps
module pdps_top_tb_top;
  import pdps_pkg::*;
  logic ref_clk = 0, rst_n = 0, hwrite = 0, rom_off = 0, bus16 = 0;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 0, hrdata, rd_q;
  logic        hready, hreadyout, hresp;
  logic [7:0]  gpio_in, ebc_in, trace_in, pin_in = 8'h96;
  pdps_drive_t gpio_drv = {8'ha5, 8'h0f}, ebc_drv = {8'h3c, 8'hf0};
  pdps_drive_t trace_drv = {8'hc3, 8'hff}, pin_drv, e;
  int bad_count = 0, cmp_count = 0;
  assign hready = hreadyout; // single slave
  always #2 ref_clk = ~ref_clk;
  pdps_top dut_u (.ref_clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
    .mode_ext_rom_off(rom_off), .mode_bus16(bus16), .gpio_drv, .gpio_in,
    .ebc_drv, .ebc_in, .trace_drv, .trace_in, .pin_in, .pin_drv);
  task chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // one single transfer; only the watchdog ends a wait on hready
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'b10; haddr <= a; hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd_q = hrdata; // data phase value, before this edge's update lands
  endtask
  task do_reset(input logic ro, input logic b16);
    rst_n <= 0; rom_off <= ro; bus16 <= b16;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1;
    repeat (2) @(posedge ref_clk);
  endtask
  // strap-dependent reset value of the lower select field; the upper one resets to zero
  task t_reset(input logic ro, input logic b16, input logic [31:0] xa);
    do_reset(ro, b16);
    ahb(0, 12'h0, 0); chk(rd_q, xa);
    ahb(0, 12'h4, 0); chk(rd_q, 32'h0);
  endtask
  // all ones everywhere: only the live bits may stick
  task t_regs;
    logic [11:0] a[6] = '{12'h0, 12'h4, 12'h8, 12'hc, 12'h10, 12'h14};
    logic [31:0] x[6] = '{32'hffff, 32'hff00, 0, 0, 32'h00ff, 0};
    foreach (a[i]) ahb(1, a[i], 32'hffff_ffff);
    foreach (a[i]) begin
      ahb(0, a[i], 0); chk(rd_q, x[i]);
    end
  endtask
  // every select code on all eight pins, checked one edge after it lands
  task t_mux;
    for (int c = 0; c < 4; c++) begin
      ahb(1, 12'h0, {16'h0, {8{c[0]}}, 8'h00});
      ahb(1, 12'h4, {16'h0, {8{c[1]}}, 8'h00});
      @(posedge ref_clk); #1;
      e = c == 0 ? gpio_drv : c == 1 ? ebc_drv : 16'h0;
      if (c == 2) e = {trace_drv.out, trace_drv.oe & 8'hcf};
      chk({pin_drv.out & e.oe, pin_drv.oe}, {e.out & e.oe, e.oe});
      chk({gpio_in, ebc_in, trace_in}, {c == 0 ? pin_in : 8'h0,
        c == 1 ? pin_in : 8'h0, c == 2 ? pin_in : 8'h0});
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    wrap_up;
  end
  initial begin
    t_reset(1, 1, 32'hffff);
    t_reset(0, 0, 32'h0);
    t_reset(1, 0, 32'h00ff);
    t_regs;
    t_mux;
    wrap_up;
  end
endmodule
